// ---- design/qihf_regs.sv ----
// Purpose : interrupt status, rx frame count, tx space request and
//           multicast hash table registers behind a wishbone slave
// Assumes : 16-bit registers in the low half of 32-bit words
// Notes   : ack is registered; unmapped words ack and read zero
`timescale 1ns/10ps
`default_nettype none
`include "qihf_params.svh"

// Operation
// - tx space flag bit 6 sets on space, cleared by writing one
// - wake-frame bit 5 read-only, cleared by power field code 1000
// - magic-frame bit 4 read-only, cleared by power field code 0100
// - link-up wake bit 3 read-only, cleared by power field code 0010
// - energy wake bit 2 read-only, cleared by code 0001
// - count bits 15:8 capture queued frames when rx interrupt raised
// - with threshold enable, rx bit 13 sets when count exceeds threshold
// - with tx monitor on, bit 6 sets once free space suffices
// - 64-bit hash table used only in hash filtering mode
// - hash index is top six crc bits over destination address
// - index top two bits pick word, low four pick bit
// - set bit passes group frame, clear bit drops; table resets zero
// - accept-all or accept-multicast passes every multicast frame
// - reading status clears nothing; written ones clear only bits 13 and 6
// - interrupt output high while enabled status bit is set
module qihf_regs
   import qihf_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic           wb_cyc_i,
   input  wire logic           wb_stb_i,
   input  wire logic           wb_we_i,
   input  wire logic [9:0]     wb_adr_i,
   input  wire logic [3:0]     wb_sel_i,
   input  wire logic [31:0]    wb_dat_i,
   output logic [31:0]         wb_dat_o,
   output logic                wb_ack_o,
   output logic                irq,
   input  wire logic           rx_frame_evt,
   input  wire logic [7:0]     queued_frames,
   input  wire logic [15:0]    tx_free_space,
   input  wire logic           wakeup_frame_evt,
   input  wire logic           magic_frame_evt,
   input  wire logic           linkup_wake_evt,
   input  wire logic           energy_wake_evt,
   input  wire qihf_da_req_t   da_req,
   output qihf_filt_res_t      filt_res
);

   logic [1:0]  rst_pipe;
   logic        rst_s_n;
   logic        req;
   logic        wr;
   logic [7:0]  idx;
   logic [15:0] wdat;
   logic [15:0] wmask;
   logic [15:0] interrupt_enable;
   logic [15:0] queue_ctrl;
   logic [7:0]  power_mgmt_control;
   logic [7:0]  queued_frame_count;
   logic [7:0]  frame_count_threshold;
   logic [15:0] next_tx_space_request;
   logic [63:0] hash_table;
   logic        rx_flag;
   logic        tx_space_avail_flag;
   logic        wakeup_frame_flag;
   logic        magic_frame_flag;
   logic        linkup_wake_flag;
   logic        energy_wake_flag;
   logic [15:0] interrupt_status;
   logic        rx_over;
   logic        rx_over_q;
   logic        rx_set;
   logic        tx_enough;
   logic        tx_enough_q;
   logic        tx_set;
   logic        pm_wr;
   logic [3:0]  pm_code;
   logic [15:0] st_clr;
   logic [15:0] next_rdata;
   qihf_filt_ctrl_t fctrl;

   // true when the access hits the given word index
   function automatic logic hit(input logic [7:0] a, input logic [7:0] i);
      return a == i;
   endfunction

   // reset release through two flops; assert is immediate
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe <= 2'b00;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_s_n = rst_pipe[1];

   // bus decode; writes land on the edge where the master sees ack
   assign req   = wb_cyc_i & wb_stb_i;
   assign wr    = req & wb_we_i & wb_ack_o;
   assign idx   = wb_adr_i[9:2];
   assign wdat  = wb_dat_i[15:0];
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // registered ack, one cycle per request, dropped the cycle after
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req & ~wb_ack_o;
   end

   // interrupt enable, queue control and power field
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         interrupt_enable   <= `QIHF_RST_WORD;
         queue_ctrl         <= `QIHF_RST_WORD;
         power_mgmt_control <= 8'h00;
      end
      else if (wr)
      begin
         if (hit(idx, `QIHF_IDX_INT_ENABLE))
            interrupt_enable <= (interrupt_enable & ~wmask) | (wdat & wmask);
         else if (hit(idx, `QIHF_IDX_QUEUE_CTRL))
            queue_ctrl <= (queue_ctrl & ~wmask) | (wdat & wmask);
         else if (hit(idx, `QIHF_IDX_PM_CONTROL) && wb_sel_i[0])
            power_mgmt_control <= wdat[7:0];
      end
   end

   // threshold, tx request and hash table
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         frame_count_threshold <= `QIHF_RST_COUNT;
         next_tx_space_request <= `QIHF_RST_WORD;
         hash_table            <= `QIHF_RST_HASH;
      end
      else if (wr)
      begin
         if (hit(idx, `QIHF_IDX_RX_FCOUNT) && wb_sel_i[0])
            frame_count_threshold <= wdat[7:0];
         else if (hit(idx, `QIHF_IDX_TX_REQUEST))
            next_tx_space_request <= (next_tx_space_request & ~wmask)
                                     | (wdat & wmask);
         else if (hit(idx, `QIHF_IDX_HASH0))
            hash_table[15:0] <= (hash_table[15:0] & ~wmask) | (wdat & wmask);
         else if (hit(idx, `QIHF_IDX_HASH1))
            hash_table[31:16] <= (hash_table[31:16] & ~wmask)
                                 | (wdat & wmask);
         else if (hit(idx, `QIHF_IDX_HASH2))
            hash_table[47:32] <= (hash_table[47:32] & ~wmask)
                                 | (wdat & wmask);
         else if (hit(idx, `QIHF_IDX_HASH3))
            hash_table[63:48] <= (hash_table[63:48] & ~wmask)
                                 | (wdat & wmask);
      end
   end

   // event detection: rising edges of the threshold and tx space compares so a cleared flag is not re-set at once; rx_frame_evt used as is
   assign rx_over   = queued_frames > frame_count_threshold;
   assign rx_set    = queue_ctrl[`QIHF_BIT_RX_THRESH_EN]
                      ? (rx_over & ~rx_over_q)
                      : rx_frame_evt;
   assign tx_enough = queue_ctrl[`QIHF_BIT_TX_MONITOR]
                      & (tx_free_space >= next_tx_space_request);
   assign tx_set    = tx_enough & ~tx_enough_q;

   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         rx_over_q   <= 1'b0;
         tx_enough_q <= 1'b0;
      end
      else
      begin
         rx_over_q   <= rx_over;
         tx_enough_q <= tx_enough;
      end
   end

   // frame count captured as the rx interrupt is raised
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
         queued_frame_count <= `QIHF_RST_COUNT;
      else if (rx_set)
         queued_frame_count <= queued_frames;
   end

   // write-one-to-clear mask and power field clear code
   assign st_clr  = (wr && hit(idx, `QIHF_IDX_INT_STATUS))
                    ? (wdat & wmask) : 16'h0000;
   assign pm_wr   = wr & hit(idx, `QIHF_IDX_PM_CONTROL) & wb_sel_i[0];
   assign pm_code = wdat[5:2];

   // w1c flags; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         rx_flag             <= 1'b0;
         tx_space_avail_flag <= 1'b0;
      end
      else
      begin
         rx_flag <= rx_set | (rx_flag & ~st_clr[`QIHF_BIT_RX]);
         tx_space_avail_flag <= tx_set
            | (tx_space_avail_flag & ~st_clr[`QIHF_BIT_TXSPACE]);
      end
   end

   // wake flags cleared only through the power field code
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         wakeup_frame_flag <= 1'b0;
         magic_frame_flag  <= 1'b0;
         linkup_wake_flag  <= 1'b0;
         energy_wake_flag  <= 1'b0;
      end
      else
      begin
         wakeup_frame_flag <= wakeup_frame_evt | (wakeup_frame_flag
            & ~(pm_wr && pm_code == `QIHF_PM_CLR_WAKEFRAME));
         magic_frame_flag <= magic_frame_evt | (magic_frame_flag
            & ~(pm_wr && pm_code == `QIHF_PM_CLR_MAGIC));
         linkup_wake_flag <= linkup_wake_evt | (linkup_wake_flag
            & ~(pm_wr && pm_code == `QIHF_PM_CLR_LINKUP));
         energy_wake_flag <= energy_wake_evt | (energy_wake_flag
            & ~(pm_wr && pm_code == `QIHF_PM_CLR_ENERGY));
      end
   end

   // status image; bits 1 and 0 are constant zero
   always_comb
   begin
      interrupt_status = 16'h0000;
      interrupt_status[`QIHF_BIT_RX]        = rx_flag;
      interrupt_status[`QIHF_BIT_TXSPACE]   = tx_space_avail_flag;
      interrupt_status[`QIHF_BIT_WAKEFRAME] = wakeup_frame_flag;
      interrupt_status[`QIHF_BIT_MAGIC]     = magic_frame_flag;
      interrupt_status[`QIHF_BIT_LINKUP]    = linkup_wake_flag;
      interrupt_status[`QIHF_BIT_ENERGY]    = energy_wake_flag;
   end

   // energy wake is enabled by either the plain or the delayed enable
   assign irq = |(interrupt_status & interrupt_enable)
                | (energy_wake_flag
                   & interrupt_enable[`QIHF_BIT_DELAY_ENERGY]);

   // read mux
   always_comb
   begin
      next_rdata = 16'h0000;
      if (hit(idx, `QIHF_IDX_INT_ENABLE))
         next_rdata = interrupt_enable;
      else if (hit(idx, `QIHF_IDX_INT_STATUS))
         next_rdata = interrupt_status;
      else if (hit(idx, `QIHF_IDX_RX_FCOUNT))
         next_rdata = {queued_frame_count, frame_count_threshold};
      else if (hit(idx, `QIHF_IDX_TX_REQUEST))
         next_rdata = next_tx_space_request;
      else if (hit(idx, `QIHF_IDX_HASH0))
         next_rdata = hash_table[15:0];
      else if (hit(idx, `QIHF_IDX_HASH1))
         next_rdata = hash_table[31:16];
      else if (hit(idx, `QIHF_IDX_HASH2))
         next_rdata = hash_table[47:32];
      else if (hit(idx, `QIHF_IDX_HASH3))
         next_rdata = hash_table[63:48];
      else if (hit(idx, `QIHF_IDX_PM_CONTROL))
         next_rdata = {8'h00, power_mgmt_control};
      else if (hit(idx, `QIHF_IDX_QUEUE_CTRL))
         next_rdata = queue_ctrl;
   end

   // read data registered with the ack; upper half always zero
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
         wb_dat_o <= 32'h0000_0000;
      else if (req & ~wb_ack_o)
         wb_dat_o <= {16'h0000, next_rdata};
   end

   // filter steering
   assign fctrl.accept_all   = queue_ctrl[`QIHF_BIT_ACCEPT_ALL];
   assign fctrl.accept_mcast = queue_ctrl[`QIHF_BIT_ACCEPT_MCAST];
   assign fctrl.hash_mode    = queue_ctrl[`QIHF_BIT_HASH_MODE];

   qihf_hash_filter u_filter
   (
      .clk        (clk),
      .rst_n      (rst_s_n),
      .req        (da_req),
      .table_bits (hash_table),
      .ctrl       (fctrl),
      .res        (filt_res)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_s_n);

   sequence status_write_s(int b);
      wr && hit(idx, `QIHF_IDX_INT_STATUS) && wb_sel_i[0] && wdat[b];
   endsequence

   sequence pm_write_s(logic [3:0] code);
      pm_wr && pm_code == code;
   endsequence

   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   txspace_clear_a: assert property (
      status_write_s(`QIHF_BIT_TXSPACE) ##0 !tx_set
      |=> !tx_space_avail_flag)
      else $error("tx space flag not cleared by write one");

   wakeframe_clear_a: assert property (
      pm_write_s(`QIHF_PM_CLR_WAKEFRAME) ##0 !wakeup_frame_evt
      |=> !wakeup_frame_flag)
      else $error("wake frame flag not cleared");

   magic_clear_a: assert property (
      pm_write_s(`QIHF_PM_CLR_MAGIC) ##0 !magic_frame_evt
      |=> !magic_frame_flag)
      else $error("magic frame flag not cleared");

   linkup_clear_a: assert property (
      pm_write_s(`QIHF_PM_CLR_LINKUP) ##0 !linkup_wake_evt
      |=> !linkup_wake_flag)
      else $error("linkup flag not cleared");

   energy_keep_a: assert property (
      energy_wake_flag && !(pm_wr && pm_code == `QIHF_PM_CLR_ENERGY)
      |=> energy_wake_flag)
      else $error("energy flag lost without clear code");

   count_capture_a: assert property (
      rx_set |=> rx_flag && queued_frame_count == $past(queued_frames))
      else $error("frame count not captured with rx interrupt");

   rx_threshold_a: assert property (
      queue_ctrl[`QIHF_BIT_RX_THRESH_EN] && !rx_over
      ##1 queue_ctrl[`QIHF_BIT_RX_THRESH_EN]
      && queued_frames > frame_count_threshold
      |=> rx_flag)
      else $error("rx flag not set above threshold");

   txspace_set_a: assert property (
      !tx_enough ##1 queue_ctrl[`QIHF_BIT_TX_MONITOR]
      && tx_free_space >= next_tx_space_request
      |=> tx_space_avail_flag)
      else $error("tx space flag not set");

   status_read_a: assert property (
      req && !wb_we_i && !rx_set && !tx_set && !wakeup_frame_evt
      && !magic_frame_evt && !linkup_wake_evt && !energy_wake_evt
      && !pm_wr
      |=> $stable(interrupt_status))
      else $error("status changed on a read");

   irq_level_a: assert property (
      (rx_flag && interrupt_enable[`QIHF_BIT_RX])
      || (tx_space_avail_flag && interrupt_enable[`QIHF_BIT_TXSPACE])
      |-> irq)
      else $error("irq low with enabled status bit");

   reserved_zero_a: assert property (
      wb_ack_o && $past(idx) == `QIHF_IDX_INT_STATUS |-> wb_dat_o[1:0] == 2'h0)
      else $error("reserved status bits read nonzero");

endmodule
`default_nettype wire

// ---- design/qihf_params.svh ----
// Purpose : offsets, field positions and reset values of the queue status
//           and hash filter register bank
// Assumes : register offsets are word indices; byte address is index * 4
// Notes   : definitions only
`ifndef QIHF_PARAMS_SVH
`define QIHF_PARAMS_SVH

// register indices
`define QIHF_IDX_INT_ENABLE    8'h90
`define QIHF_IDX_INT_STATUS    8'h92
`define QIHF_IDX_RX_FCOUNT     8'h9c
`define QIHF_IDX_TX_REQUEST    8'h9e
`define QIHF_IDX_HASH0         8'ha0
`define QIHF_IDX_HASH1         8'ha2
`define QIHF_IDX_HASH2         8'ha4
`define QIHF_IDX_HASH3         8'ha6
`define QIHF_IDX_PM_CONTROL    8'hd4
`define QIHF_IDX_QUEUE_CTRL    8'he0

// interrupt status / enable bit positions
`define QIHF_BIT_RX            13
`define QIHF_BIT_TXSPACE       6
`define QIHF_BIT_WAKEFRAME     5
`define QIHF_BIT_MAGIC         4
`define QIHF_BIT_LINKUP        3
`define QIHF_BIT_ENERGY        2
`define QIHF_BIT_DELAY_ENERGY  0

// queue control register bit positions
`define QIHF_BIT_TX_MONITOR    1
`define QIHF_BIT_RX_THRESH_EN  5
`define QIHF_BIT_ACCEPT_ALL    8
`define QIHF_BIT_ACCEPT_MCAST  9
`define QIHF_BIT_HASH_MODE     10

// power-management clear field codes, bits 5:2
`define QIHF_PM_CLR_WAKEFRAME  4'h8
`define QIHF_PM_CLR_MAGIC      4'h4
`define QIHF_PM_CLR_LINKUP     4'h2
`define QIHF_PM_CLR_ENERGY     4'h1

// reset values
`define QIHF_RST_WORD          16'h0000
`define QIHF_RST_HASH          64'h0000_0000_0000_0000
`define QIHF_RST_COUNT         8'h00

// hash crc
`define QIHF_CRC_POLY          32'h04c1_1db7
`define QIHF_CRC_INIT          32'hffff_ffff

`endif

// ---- design/qihf_pkg.sv ----
// Purpose : types shared by the queue status and hash filter bank
// Assumes : nothing
// Notes   : constants live in qihf_params.svh
package qihf_pkg;

   // destination address offered by the receive path
   typedef struct packed
   {
      logic        valid;
      logic [47:0] da;
   } qihf_da_req_t;

   // filter verdict, one-cycle done pulse
   typedef struct packed
   {
      logic       done;
      logic       pass;
      logic [5:0] index;
   } qihf_filt_res_t;

   // filter steering bits
   typedef struct packed
   {
      logic accept_all;
      logic accept_mcast;
      logic hash_mode;
   } qihf_filt_ctrl_t;

endpackage

// ---- design/qihf_hash_filter.sv ----
// Purpose : multicast hash filter on the received destination address
// Assumes : da[47:40] is the first byte on the wire, bits sent lsb first
// Notes   : verdict is registered, one cycle after the request
`timescale 1ns/10ps
`default_nettype none
`include "qihf_params.svh"

module qihf_hash_filter
   import qihf_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire qihf_da_req_t    req,
   input  wire logic [63:0]     table_bits,
   input  wire qihf_filt_ctrl_t ctrl,
   output var  qihf_filt_res_t  res
);

   // ethernet frame check crc over the 48 address bits
   function automatic logic [31:0] crc48(input logic [47:0] a);
      logic [31:0] c;
      logic        fb;
      c = `QIHF_CRC_INIT;
      for (int b = 0; b < 6; b++)
      begin
         for (int i = 0; i < 8; i++)
         begin
            fb = c[31] ^ a[47 - 8*b - 7 + i];
            c  = {c[30:0], 1'b0};
            if (fb)
               c = c ^ `QIHF_CRC_POLY;
         end
      end
      return c;
   endfunction

   logic [31:0] crc;
   logic [5:0]  idx;
   logic        group;
   logic        next_pass;

   assign crc   = crc48(req.da);
   assign idx   = crc[31:26];
   assign group = req.da[40];    // i/g bit of the first byte

   // table word by idx[5:4], bit by idx[3:0]; word 0 is index 0
   always_comb
   begin
      next_pass = 1'b1;
      if (group)
      begin
         if (ctrl.accept_all || ctrl.accept_mcast)
            next_pass = 1'b1;
         else if (ctrl.hash_mode)
            next_pass = table_bits[{idx[5:4], idx[3:0]}];
      end
   end

   // registered verdict
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         res <= '0;
      else
      begin
         res.done  <= req.valid;
         res.pass  <= req.valid & next_pass;
         res.index <= idx;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   filter_drop_a: assert property (
      req.valid && group && !ctrl.accept_all && !ctrl.accept_mcast
      && ctrl.hash_mode && !table_bits[idx]
      |=> res.done && !res.pass)
      else $error("cleared hash bit did not drop frame");

   accept_all_a: assert property (
      req.valid && (ctrl.accept_all || ctrl.accept_mcast)
      |=> res.done && res.pass)
      else $error("accept-all did not pass frame");

endmodule
`default_nettype wire

// ---- test/qihf_host_model.sv ----
// Purpose : host side model, a classic wishbone master for the bank
// Assumes : xfer is entered just after a rising clock edge
// Notes   : waits on ack with no fixed latency; address and data scramble
//           when idle so stale values are never mistaken for live ones
`timescale 1ns/10ps
`default_nettype none
module qihf_host_model
(
   input  wire logic        clk,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [9:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      wdat
);
   // bus idle at time zero
   initial
   begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 10'h000;
      sel = 4'h0;
      wdat = 32'h0000_0000;
   end

   // one classic cycle; request held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [15:0] d, output logic [15:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'h3;
      wdat <= {16'h0000, d};
      @(posedge clk);
      // no latency assumed; only the bench watchdog ends a lost answer
      while (ack !== 1'b1)
         @(posedge clk);
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      adr <= ~adr;
      wdat <= ~wdat;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ---- test/queue_irq_status_and_hash_filter_tb.sv ----
// Purpose : self-checking bench for the status, count and hash bank
// Assumes : 10 MHz clock, reset held six cycles
// Notes   : register rows first, then flags, irq and filter by hand
`timescale 1ns/10ps
`default_nettype none
module queue_irq_status_and_hash_filter_tb
   import qihf_pkg::*;
;
   logic           clk, rst_n, cyc, stb, we, ack, irq, rxe;
   logic [9:0]     adr;
   logic [3:0]     sel, wk;
   logic [31:0]    wdat, rdat;
   logic [7:0]     qf;
   logic [15:0]    txf, q;
   logic [47:0]    da;
   logic [5:0]     ix;
   qihf_da_req_t   req;
   qihf_filt_res_t res;
   int             failures, comparisons;
   // register rows: index, write value, read-back value
   logic [7:0]  ri [7] = '{8'ha0, 8'ha2, 8'ha4, 8'h9e, 8'h9c, 8'h92, 8'h94};
   logic [15:0] rw [7] = '{16'ha5c3, 16'h5a3c, 16'h0ff0, 16'h1234,
                           16'hff7f, 16'hffff, 16'hffff};
   logic [15:0] re [7] = '{16'ha5c3, 16'h5a3c, 16'h0ff0, 16'h1234,
                           16'h007f, 16'h0000, 16'h0000};
   // filter mode rows: queue control value and expected verdict
   logic [15:0] fc [4] = '{16'h0400, 16'h0500, 16'h0600, 16'h0000};
   logic        fp [4] = '{1'b0, 1'b1, 1'b1, 1'b1};

   qihf_regs u_qihf_regs (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
      .rx_frame_evt(rxe), .queued_frames(qf), .tx_free_space(txf),
      .wakeup_frame_evt(wk[3]), .magic_frame_evt(wk[2]),
      .linkup_wake_evt(wk[1]), .energy_wake_evt(wk[0]), .da_req(req),
      .filt_res(res));

   qihf_host_model u_qihf_host_model (.clk(clk), .ack(ack), .rdat(rdat),
      .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat));

   // free-running clock, 100 ns period
   always #50 clk = ~clk;

   task automatic chk(input string nm, input logic [15:0] got, exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      u_qihf_host_model.xfer(1'b1, idx, d, q);
   endtask

   task automatic rc(input string nm, input logic [7:0] idx,
                     input logic [15:0] exp);
      u_qihf_host_model.xfer(1'b0, idx, 16'h0000, q);
      chk(nm, q, exp);
   endtask

   // verdict is registered, so look just after the edge that takes it
   task automatic filt(input logic [47:0] a, input logic p);
      req.valid <= 1'b1;
      req.da <= a;
      @(posedge clk);
      req.valid <= 1'b0;
      req.da <= ~a;
      #1;
      chk("filt", {res.done, res.pass, 8'h00, res.index},
          {1'b1, p, 8'h00, ix});
      @(posedge clk);
   endtask

   // bench's own hash: lsb first per byte, top six bits of the crc
   function automatic logic [5:0] hidx(input logic [47:0] a);
      logic [31:0] c;
      logic        b;
      c = 32'hffff_ffff;
      for (int i = 0; i < 48; i++)
      begin
         b = c[31] ^ a[40 - 8 * (i / 8) + i % 8];
         c = {c[30:0], 1'b0} ^ (b ? 32'h04c1_1db7 : 32'h0000_0000);
      end
      return c[31:26];
   endfunction

   task automatic summarize();
      if (failures == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // hang guard, well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (6000) @(posedge clk);
      failures++;
      summarize();
   end

   // main sequence
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      rxe = 1'b0;
      wk = 4'h0;
      qf = 8'h00;
      txf = 16'h0000;
      req = '0;
      failures = 0;
      comparisons = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 7; i++)
      begin
         rc("rst", ri[i], 16'h0000);
         wr(ri[i], rw[i]);
         rc("rw", ri[i], re[i]);
      end
      // wake flags ignore status writes, clear only by their own code
      for (int k = 0; k < 4; k++)
      begin
         wk[k] <= 1'b1;
         @(posedge clk);
         wk <= 4'h0;
         @(posedge clk);
         wr(8'h92, 16'hffff);
         rc("wake", 8'h92, 16'h0004 << k);
         wr(8'hd4, 16'h0004 << k);
         rc("wclr", 8'h92, 16'h0000);
      end
      // delayed energy wake raises irq through enable bit 0
      wk[0] <= 1'b1;
      @(posedge clk);
      wk <= 4'h0;
      wr(8'h90, 16'h0001);
      chk("irq_d", {15'h0000, irq}, 16'h0001);
      wr(8'h90, 16'h0040);
      chk("irq_m", {15'h0000, irq}, 16'h0000);
      wr(8'hd4, 16'h0004);
      // tx space: equal free space is enough, one short is not
      wr(8'h9e, 16'h0100);
      txf <= 16'h00ff;
      wr(8'he0, 16'h0002);
      rc("tx_lo", 8'h92, 16'h0000);
      txf <= 16'h0100;
      repeat (2) @(posedge clk);
      rc("tx_on", 8'h92, 16'h0040);
      chk("irq_t", {15'h0000, irq}, 16'h0001);
      wr(8'h92, 16'h0040);
      rc("tx_clr", 8'h92, 16'h0000);
      // rx threshold: equal count does not fire, one more does
      qf <= 8'h03;
      wr(8'h9c, 16'h0003);
      wr(8'he0, 16'h0020);
      rc("rx_eq", 8'h92, 16'h0000);
      qf <= 8'h04;
      repeat (2) @(posedge clk);
      rc("rx_set", 8'h92, 16'h2000);
      rc("rx_cnt", 8'h9c, 16'h0403);
      wr(8'h92, 16'h2000);
      rc("rx_clr", 8'h92, 16'h0000);
      // threshold mode off: a frame pulse raises the rx flag instead
      wr(8'he0, 16'h0000);
      qf <= 8'h07;
      rxe <= 1'b1;
      @(posedge clk);
      rxe <= 1'b0;
      @(posedge clk);
      wr(8'h90, 16'h2000);
      chk("irq_r", {15'h0000, irq}, 16'h0001);
      rc("rx_cnt2", 8'h9c, 16'h0703);
      wr(8'h92, 16'h2000);
      chk("irq_rc", {15'h0000, irq}, 16'h0000);
      // hash filter: only the addressed table bit set
      da = 48'h0100_5e00_00fb;
      ix = hidx(da);
      for (int j = 0; j < 4; j++)
         wr(8'ha0 + 8'(2 * j),
            (ix[5:4] == j) ? (16'h0001 << ix[3:0]) : 16'h0000);
      wr(8'he0, 16'h0400);
      filt(da, 1'b1);
      wr(8'ha0 + {5'h00, ix[5:4], 1'b0}, 16'h0000);
      for (int m = 0; m < 4; m++)
      begin
         wr(8'he0, fc[m]);
         filt(da, fp[m]);
      end
      // reset in mid-run; first request waits out the release flops
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rc("rst2_cnt", 8'h9c, 16'h0000);
      rc("rst2_tx", 8'h9e, 16'h0000);
      rc("rst2_en", 8'h90, 16'h0000);
      summarize();
   end
endmodule
`default_nettype wire
